// file: dma_ctrl.sv
// Purpose: four channel programmable transfer engine with register port
// Assumes: all inputs but reset_n synchronous to clk; one clock, stoppable
// Notes: all outputs are flip-flops; registers reached during idle only
`timescale 1ns/1ps
module dma_ctrl (
  input wire logic clk,
  input wire logic reset_n,
  input wire logic chip_select_n,
  input wire logic [3:0] register_select_in,
  input wire logic [7:0] data_bus_in,
  input wire logic io_read_strobe_in_n,
  input wire logic io_write_strobe_in_n,
  input wire logic [dma_pkg::CH_N-1:0] channel_request,
  input wire logic bus_hold_grant,
  input wire logic ready,
  input wire logic terminate_in_n,
  output logic [dma_pkg::CH_N-1:0] channel_grant,
  output logic bus_hold_request,
  output logic [3:0] low_transfer_address_out,
  output logic [3:0] high_transfer_address_out,
  output logic address_out_valid_n,
  output logic upper_byte_latch_strobe,
  output logic upper_byte_bus_enable,
  output logic [7:0] data_bus_out,
  output logic data_out_valid_n,
  output logic io_read_strobe_out_n,
  output logic io_write_strobe_out_n,
  output logic command_out_valid_n,
  output logic mem_read_strobe_n,
  output logic mem_write_strobe_n,
  output logic finished_out_n,
  output logic finished_out_valid_n
);
  import dma_pkg::*;

  // ---------------------------------------------------------------
  // helpers
  // ---------------------------------------------------------------
  // winner scan from the top-priority channel upward
  function automatic logic [1:0] pick(input logic [3:0] pend,
                                      input logic [1:0] top);
    logic [1:0] c;
    logic [1:0] w;
    w = top;
    for (int i = 3; i >= 0; i--) begin
      c = top + 2'(i);
      if (pend[c]) begin
        w = c;
      end
    end
    return w;
  endfunction

  // channel addressed by a select code below 8
  function automatic logic [1:0] reg_ch(input logic [3:0] sel);
    return sel[2:1];
  endfunction

  // ---------------------------------------------------------------
  // state
  // ---------------------------------------------------------------
  state_e state_q, state_d; // sequencer
  logic [7:0] cmdr_q, cmdr_d; // command register
  logic [3:0] mask_q, mask_d; // per channel masks
  logic [3:0] swreq_q, swreq_d; // software requests
  logic [3:0] tc_q, tc_d; // terminal count status, sticky
  logic ff_q, ff_d; // byte pointer: 0 low, 1 high
  mode_s mode_q [CH_N], mode_d [CH_N];
  logic [AW-1:0] base_a_q [CH_N], base_a_d [CH_N];
  logic [AW-1:0] cur_a_q [CH_N], cur_a_d [CH_N];
  logic [AW-1:0] base_c_q [CH_N], base_c_d [CH_N];
  logic [AW-1:0] cur_c_q [CH_N], cur_c_d [CH_N];
  logic [1:0] act_q, act_d; // channel in service
  logic [1:0] top_q, top_d; // highest priority channel
  logic [7:0] hold_q, hold_d; // copy holding byte
  logic wph_q, wph_d; // copy: write half in progress
  logic wrp_q, wrp_d; // previous write strobe level
  logic rdp_q, rdp_d; // previous read strobe level
  // output flops
  logic hrq_q, hrq_d;
  logic [3:0] gnt_q, gnt_d;
  logic [AW-1:0] ao_q, ao_d; // full transfer address
  logic aval_n_q, aval_n_d;
  logic stb_q, stb_d;
  logic aen_q, aen_d;
  logic [7:0] dout_q, dout_d;
  logic dval_n_q, dval_n_d;
  cmd_s cmd_q, cmd_d; // active-high strobe copies
  logic cval_n_q, cval_n_d;
  logic fin_n_q, fin_n_d;
  logic finv_n_q, finv_n_d;

  // combinational helpers
  logic [3:0] eff_req; // requests after polarity
  logic [3:0] pend; // unmasked pending requests
  logic host_ok; // register port usable
  logic wr_edge; // write strobe just fell
  logic rd_edge; // read strobe just fell
  logic m2m; // copy mode active
  logic [1:0] ach; // channel whose address is driven
  logic eop; // service ends after this byte
  logic [7:0] rdval; // register read value

  // ---------------------------------------------------------------
  // request conditioning and port qualification
  // ---------------------------------------------------------------
  always_comb begin
    eff_req = (channel_request ^ {4{cmdr_q[CMD_REQLO]}}) | swreq_q;
    pend = eff_req & ~mask_q;
    // the port only answers while we do not own the bus
    host_ok = !chip_select_n && (state_q == st_idle) && !bus_hold_grant;
    wr_edge = host_ok && !io_write_strobe_in_n && wrp_q;
    rd_edge = host_ok && !io_read_strobe_in_n && rdp_q;
    m2m = cmdr_q[CMD_M2M];
    ach = (m2m && wph_q) ? 2'h1 : act_q;
    rdval = 8'h00;
    if (register_select_in[3] == 1'b0) begin
      if (register_select_in[0]) begin
        rdval = ff_q ? cur_c_q[reg_ch(register_select_in)][15:8]
                     : cur_c_q[reg_ch(register_select_in)][7:0];
      end else begin
        rdval = ff_q ? cur_a_q[reg_ch(register_select_in)][15:8]
                     : cur_a_q[reg_ch(register_select_in)][7:0];
      end
    end else if (register_select_in == SEL_CMD) begin
      rdval = {eff_req, tc_q};
    end else begin
      rdval = {4'h0, mask_q};
    end
  end

  // ---------------------------------------------------------------
  // next-state logic: registers, arbitration, sequencing
  // ---------------------------------------------------------------
  always_comb begin
    state_d = state_q;
    cmdr_d = cmdr_q;
    mask_d = mask_q;
    swreq_d = swreq_q;
    tc_d = tc_q;
    ff_d = ff_q;
    mode_d = mode_q;
    base_a_d = base_a_q;
    cur_a_d = cur_a_q;
    base_c_d = base_c_q;
    cur_c_d = cur_c_q;
    act_d = act_q;
    top_d = cmdr_q[CMD_ROT] ? top_q : 2'h0;
    hold_d = hold_q;
    wph_d = wph_q;
    wrp_d = io_write_strobe_in_n;
    rdp_d = io_read_strobe_in_n;
    hrq_d = hrq_q;
    ao_d = ao_q;
    aval_n_d = 1'b1;
    stb_d = 1'b0;
    aen_d = 1'b0;
    dout_d = 8'h00;
    dval_n_d = 1'b1;
    cmd_d = '0;
    cval_n_d = 1'b1;
    fin_n_d = 1'b1;
    finv_n_d = 1'b1;
    eop = 1'b0;
    // register reads: data held while the strobe is low
    if (host_ok && !io_read_strobe_in_n) begin
      dout_d = rdval;
      dval_n_d = 1'b0;
    end
    if (rd_edge) begin
      if (register_select_in[3] == 1'b0) begin
        ff_d = !ff_q;
      end else if (register_select_in == SEL_CMD) begin
        tc_d = 4'h0; // reading status clears it; a set below wins
      end
    end
    // register writes on the falling edge of the write strobe
    if (wr_edge) begin
      if (register_select_in[3] == 1'b0) begin
        for (int i = 0; i < CH_N; i++) begin
          if (reg_ch(register_select_in) == 2'(i)) begin
            if (register_select_in[0]) begin
              if (ff_q) begin
                base_c_d[i][15:8] = data_bus_in;
              end else begin
                base_c_d[i][7:0] = data_bus_in;
              end
              cur_c_d[i] = base_c_d[i];
            end else begin
              if (ff_q) begin
                base_a_d[i][15:8] = data_bus_in;
              end else begin
                base_a_d[i][7:0] = data_bus_in;
              end
              cur_a_d[i] = base_a_d[i];
            end
          end
        end
        ff_d = !ff_q;
      end else if (register_select_in == SEL_CMD) begin
        cmdr_d = data_bus_in;
      end else if (register_select_in == SEL_SWREQ) begin
        swreq_d[data_bus_in[1:0]] = data_bus_in[2];
      end else if (register_select_in == SEL_MASK1) begin
        mask_d[data_bus_in[1:0]] = data_bus_in[2];
      end else if (register_select_in == SEL_MODE) begin
        mode_d[data_bus_in[1:0]] = mode_s'(data_bus_in[7:MODE_LSB]);
      end else if (register_select_in == SEL_CLRFF) begin
        ff_d = 1'b0;
      end else if (register_select_in == SEL_MCLR) begin
        cmdr_d = CMD_RST;
        mask_d = MASK_RST;
        swreq_d = 4'h0;
        tc_d = 4'h0;
        ff_d = 1'b0;
      end else if (register_select_in == SEL_CLRMASK) begin
        mask_d = 4'h0;
      end else begin
        mask_d = data_bus_in[3:0];
      end
    end
    case (state_q)
      st_idle: begin
        wph_d = 1'b0;
        if (pend != 4'h0 && !cmdr_q[CMD_DIS]) begin
          hrq_d = 1'b1;
          state_d = st_hold;
        end
      end
      st_hold: begin
        if (pend == 4'h0) begin
          hrq_d = 1'b0; // request vanished before the bus came
          state_d = st_idle;
        end else if (bus_hold_grant) begin
          act_d = m2m ? 2'h0 : pick(pend, top_d);
          state_d = st_addr;
        end
      end
      st_addr: begin
        // upper byte rides the data bus to an external latch
        ao_d = cur_a_q[ach];
        aval_n_d = 1'b0;
        stb_d = 1'b1;
        aen_d = 1'b1;
        dout_d = cur_a_q[ach][15:8];
        dval_n_d = 1'b0;
        state_d = st_xfer;
      end
      st_xfer: begin
        aval_n_d = 1'b0;
        aen_d = 1'b1;
        cval_n_d = 1'b0;
        if (m2m) begin
          cmd_d.mem_rd = !wph_q;
          cmd_d.mem_wr = wph_q;
          if (wph_q) begin
            dout_d = hold_q;
            dval_n_d = 1'b0;
          end
        end else if (mode_q[act_q].xtype == XT_TOMEM) begin
          cmd_d.io_rd = 1'b1;
          cmd_d.mem_wr = 1'b1;
        end else if (mode_q[act_q].xtype == XT_FROMMEM) begin
          cmd_d.mem_rd = 1'b1;
          cmd_d.io_wr = 1'b1;
        end
        // strobes stay on while ready is low: wait cycles
        if (ready && cmd_q != '0) begin
          cmd_d = '0;
          cval_n_d = 1'b1; // valid drops with the strobes
          if (m2m && !wph_q) begin
            hold_d = data_bus_in;
            if (!cmdr_q[CMD_FILL]) begin
              cur_a_d[0] = mode_q[0].dec ? cur_a_q[0] - 16'h0001
                                         : cur_a_q[0] + 16'h0001;
            end
            wph_d = 1'b1;
            state_d = st_addr;
          end else begin
            wph_d = 1'b0;
            cur_a_d[ach] = mode_q[ach].dec ? cur_a_q[ach] - 16'h0001
                                           : cur_a_q[ach] + 16'h0001;
            cur_c_d[ach] = cur_c_q[ach] - 16'h0001;
            eop = (cur_c_q[ach] == 16'h0000) || !terminate_in_n;
            if (eop) begin
              tc_d[ach] = 1'b1;
              fin_n_d = 1'b0;
              finv_n_d = 1'b0;
              if (mode_q[ach].auto) begin
                cur_a_d[ach] = base_a_q[ach];
                cur_c_d[ach] = base_c_q[ach];
                if (m2m) begin
                  cur_a_d[0] = base_a_q[0];
                end
              end else begin
                mask_d[ach] = 1'b1;
              end
              swreq_d[act_q] = 1'b0;
              state_d = st_end;
            end else if (mode_q[ach].svc == SM_BLOCK) begin
              state_d = st_addr;
            end else begin
              state_d = st_end;
            end
          end
        end else if (ready) begin
          cval_n_d = 1'b0; // first strobe cycle starts now
        end
      end
      default: begin
        // release the bus; single mode comes back via idle
        hrq_d = 1'b0;
        if (cmdr_q[CMD_ROT]) begin
          top_d = act_q + 2'h1;
        end
        state_d = st_idle;
      end
    endcase
    // grant follows the bus tenure of the winning channel
    if (state_d == st_addr || state_d == st_xfer) begin
      gnt_d = cmdr_q[CMD_GNTHI] ? (4'h1 << act_d) : ~(4'h1 << act_d);
    end else begin
      gnt_d = {4{!cmdr_q[CMD_GNTHI]}};
    end
  end

  // ---------------------------------------------------------------
  // registers; all static, so a stopped clock loses nothing
  // ---------------------------------------------------------------
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      state_q <= st_idle;
      cmdr_q <= CMD_RST;
      mask_q <= MASK_RST;
      swreq_q <= 4'h0;
      tc_q <= 4'h0;
      ff_q <= 1'b0;
      for (int i = 0; i < CH_N; i++) begin
        mode_q[i] <= mode_s'(MODE_RST);
        base_a_q[i] <= '0;
        cur_a_q[i] <= '0;
        base_c_q[i] <= '0;
        cur_c_q[i] <= '0;
      end
      act_q <= 2'h0;
      top_q <= 2'h0;
      hold_q <= 8'h00;
      wph_q <= 1'b0;
      wrp_q <= 1'b1;
      rdp_q <= 1'b1;
      hrq_q <= 1'b0;
      gnt_q <= 4'hf;
      ao_q <= '0;
      aval_n_q <= 1'b1;
      stb_q <= 1'b0;
      aen_q <= 1'b0;
      dout_q <= 8'h00;
      dval_n_q <= 1'b1;
      cmd_q <= '0;
      cval_n_q <= 1'b1;
      fin_n_q <= 1'b1;
      finv_n_q <= 1'b1;
    end else begin
      state_q <= state_d;
      cmdr_q <= cmdr_d;
      mask_q <= mask_d;
      swreq_q <= swreq_d;
      tc_q <= tc_d;
      ff_q <= ff_d;
      mode_q <= mode_d;
      base_a_q <= base_a_d;
      cur_a_q <= cur_a_d;
      base_c_q <= base_c_d;
      cur_c_q <= cur_c_d;
      act_q <= act_d;
      top_q <= top_d;
      hold_q <= hold_d;
      wph_q <= wph_d;
      wrp_q <= wrp_d;
      rdp_q <= rdp_d;
      hrq_q <= hrq_d;
      gnt_q <= gnt_d;
      ao_q <= ao_d;
      aval_n_q <= aval_n_d;
      stb_q <= stb_d;
      aen_q <= aen_d;
      dout_q <= dout_d;
      dval_n_q <= dval_n_d;
      cmd_q <= cmd_d;
      cval_n_q <= cval_n_d;
      fin_n_q <= fin_n_d;
      finv_n_q <= finv_n_d;
    end
  end

  // ---------------------------------------------------------------
  // outputs, straight from flops
  // ---------------------------------------------------------------
  assign channel_grant = gnt_q;
  assign bus_hold_request = hrq_q;
  assign low_transfer_address_out = ao_q[3:0];
  assign high_transfer_address_out = ao_q[7:4];
  assign address_out_valid_n = aval_n_q;
  assign upper_byte_latch_strobe = stb_q;
  assign upper_byte_bus_enable = aen_q;
  assign data_bus_out = dout_q;
  assign data_out_valid_n = dval_n_q;
  assign io_read_strobe_out_n = !cmd_q.io_rd;
  assign io_write_strobe_out_n = !cmd_q.io_wr;
  assign command_out_valid_n = cval_n_q;
  assign mem_read_strobe_n = !cmd_q.mem_rd;
  assign mem_write_strobe_n = !cmd_q.mem_wr;
  assign finished_out_n = fin_n_q;
  assign finished_out_valid_n = finv_n_q;
endmodule // dma_ctrl

// file: dma_pkg.sv
// Purpose: shared constants and types of the four channel transfer engine
// Assumes: 8-bit register port, 16-bit channel addresses and counts
// Notes: select codes, command bits and mode fields are fixed here; channel register and bit-select fields are decoded in dma_ctrl
package dma_pkg;
  // ---------------------------------------------------------------
  // sizes
  // ---------------------------------------------------------------
  localparam int CH_N = 4; // transfer channels
  localparam int AW = 16; // address and count width
  // ---------------------------------------------------------------
  // register select codes on the 4-bit select input
  // ---------------------------------------------------------------
  localparam logic [3:0] SEL_CMD = 4'h8; // write command, read status
  localparam logic [3:0] SEL_SWREQ = 4'h9; // software request bit
  localparam logic [3:0] SEL_MASK1 = 4'ha; // one mask bit
  localparam logic [3:0] SEL_MODE = 4'hb; // channel mode
  localparam logic [3:0] SEL_CLRFF = 4'hc; // clear byte pointer
  localparam logic [3:0] SEL_MCLR = 4'hd; // master clear
  localparam logic [3:0] SEL_CLRMASK = 4'he; // unmask all
  localparam logic [3:0] SEL_MASKALL = 4'hf; // write all mask bits
  // ---------------------------------------------------------------
  // command bit positions
  // ---------------------------------------------------------------
  localparam int CMD_M2M = 0; // memory to memory on channels 0 and 1
  localparam int CMD_FILL = 1; // source address held (block fill)
  localparam int CMD_DIS = 2; // controller disabled
  localparam int CMD_ROT = 4; // rotating priority
  localparam int CMD_REQLO = 6; // requests active low
  localparam int CMD_GNTHI = 7; // grants active high
  localparam logic [7:0] CMD_RST = 8'h00;
  localparam logic [3:0] MASK_RST = 4'hf;
  // ---------------------------------------------------------------
  // mode byte fields (bits 1:0 carry the channel number)
  // ---------------------------------------------------------------
  localparam int MODE_LSB = 2; // mode struct starts at this bit
  localparam logic [1:0] XT_TOMEM = 2'h1; // peripheral to memory
  localparam logic [1:0] XT_FROMMEM = 2'h2; // memory to peripheral
  localparam logic [1:0] SM_BLOCK = 2'h2; // whole count in one tenure
  localparam logic [5:0] MODE_RST = 6'h00;
  // channel mode as stored from data bits 7:2
  typedef struct packed {
    logic [1:0] svc; // service: block or single
    logic dec; // address counts down
    logic auto; // restore base values at terminal count
    logic [1:0] xtype; // transfer direction
  } mode_s;
  // strobe group driven during active cycles
  typedef struct packed {
    logic io_rd;
    logic io_wr;
    logic mem_rd;
    logic mem_wr;
  } cmd_s;
  // sequencer states
  typedef enum {st_idle, st_hold, st_addr, st_xfer, st_end} state_e;
endpackage

// file: dma_ctrl_sva.sv
// Purpose: port checks of the four channel transfer engine
// Assumes: one clock, asynchronous active low reset
// Notes: grant polarity may be either, so checks count grant bits
`timescale 1ns/1ps
module dma_ctrl_sva (
  input wire logic clk,
  input wire logic reset_n,
  input wire logic ready,
  input wire logic bus_hold_grant,
  input wire logic bus_hold_request,
  input wire logic [dma_pkg::CH_N-1:0] channel_grant,
  input wire logic address_out_valid_n,
  input wire logic upper_byte_latch_strobe,
  input wire logic upper_byte_bus_enable,
  input wire logic io_read_strobe_out_n,
  input wire logic io_write_strobe_out_n,
  input wire logic command_out_valid_n,
  input wire logic mem_read_strobe_n,
  input wire logic mem_write_strobe_n,
  input wire logic finished_out_n,
  input wire logic finished_out_valid_n
);
  import dma_pkg::*;
  // ----------------------------------------
  // checks
  // ----------------------------------------
  default clocking cb @(posedge clk); endclocking
  default disable iff (!reset_n);
  // whole strobe group, so a wait can hold it in one compare
  wire logic [3:0] strobes = {io_read_strobe_out_n, io_write_strobe_out_n,
    mem_read_strobe_n, mem_write_strobe_n};
  property p_own_bus;
    !command_out_valid_n |-> bus_hold_request && bus_hold_grant;
  endproperty
  a_own_bus: assert property (p_own_bus)
    else $error("strobes without bus ownership");
  property p_one_grant;
    !command_out_valid_n |->
      $countones(channel_grant) == 1 || $countones(channel_grant) == 3;
  endproperty
  a_one_grant: assert property (p_one_grant)
    else $error("not exactly one channel granted");
  property p_latch_pulse;
    upper_byte_latch_strobe |=> !upper_byte_latch_strobe;
  endproperty
  a_latch_pulse: assert property (p_latch_pulse)
    else $error("upper byte strobe longer than one cycle");
  property p_addr_valid;
    upper_byte_latch_strobe |-> !address_out_valid_n && upper_byte_bus_enable;
  endproperty
  a_addr_valid: assert property (p_addr_valid)
    else $error("address not valid in address cycle");
  property p_cmd_next;
    upper_byte_latch_strobe |=> !command_out_valid_n && upper_byte_bus_enable;
  endproperty
  a_cmd_next: assert property (p_cmd_next)
    else $error("strobes late after address cycle");
  property p_wait;
    !command_out_valid_n && !ready |=> !command_out_valid_n && $stable(strobes);
  endproperty
  a_wait: assert property (p_wait)
    else $error("strobes not held while not ready");
  property p_release;
    !command_out_valid_n && ready |=> command_out_valid_n;
  endproperty
  a_release: assert property (p_release)
    else $error("strobes not released after ready");
  property p_direct;
    !command_out_valid_n && !io_read_strobe_out_n |->
      !mem_write_strobe_n && mem_read_strobe_n;
  endproperty
  a_direct: assert property (p_direct)
    else $error("peripheral read without memory write");
  property p_finish;
    !finished_out_n |-> !finished_out_valid_n ##1 finished_out_n;
  endproperty
  a_finish: assert property (p_finish)
    else $error("finish pulse malformed");
  property p_reset_idle;
    $rose(reset_n) |-> !bus_hold_request && command_out_valid_n;
  endproperty
  a_reset_idle: assert property (p_reset_idle)
    else $error("not idle after reset");
endmodule // dma_ctrl_sva

bind dma_ctrl dma_ctrl_sva i_sva (
  .clk(clk), .reset_n(reset_n), .ready(ready),
  .bus_hold_grant(bus_hold_grant), .bus_hold_request(bus_hold_request),
  .channel_grant(channel_grant), .address_out_valid_n(address_out_valid_n),
  .upper_byte_latch_strobe(upper_byte_latch_strobe),
  .upper_byte_bus_enable(upper_byte_bus_enable),
  .io_read_strobe_out_n(io_read_strobe_out_n),
  .io_write_strobe_out_n(io_write_strobe_out_n),
  .command_out_valid_n(command_out_valid_n),
  .mem_read_strobe_n(mem_read_strobe_n),
  .mem_write_strobe_n(mem_write_strobe_n),
  .finished_out_n(finished_out_n),
  .finished_out_valid_n(finished_out_valid_n)
);

// file: host_bus_model.sv
// Purpose: host side of the bus hand-over plus a slow memory
// Assumes: slow is set by the bench between transfers
// Notes: slow mode delays the grant and holds ready low 3 of 4 cycles
`timescale 1ns/1ps
module host_bus_model (
  input wire logic clk,
  input wire logic reset_n,
  input wire logic slow,
  input wire logic bus_hold_request,
  output logic bus_hold_grant,
  output logic ready
);
  logic [2:0] tick_q; // free running pattern source
  // grant follows the request late, is taken back at once
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      bus_hold_grant <= 1'b0;
      ready <= 1'b1;
      tick_q <= 3'h0;
    end else begin
      tick_q <= tick_q + 3'h1;
      // never grant before a request, drop as soon as it goes
      bus_hold_grant <= bus_hold_request &&
        (bus_hold_grant || !slow || tick_q[0]);
      ready <= !slow || tick_q[1:0] == 2'h3;
    end
  end
endmodule // host_bus_model

// file: tb_top.sv
// Purpose: self-checking bench of the four channel transfer engine
// Assumes: reset polarity of requests (high) and grants (low)
// Notes: bench plays host register port and peripherals
`timescale 1ns/1ps
module tb_top;
  import dma_pkg::*;
  // ----------------------------------------
  // signals and scoreboard
  // ----------------------------------------
  logic clk, reset_n, chip_select_n, io_read_strobe_in_n, slow;
  logic io_write_strobe_in_n, ready, bus_hold_grant, terminate_in_n;
  logic bus_hold_request, upper_byte_latch_strobe, data_out_valid_n;
  logic finished_out_n, rd_seen;
  logic [7:0] data_bus_in, data_bus_out;
  logic [3:0] register_select_in, lo_a, hi_a, channel_request, channel_grant;
  logic [15:0] a, aq[$]; // expected transfer addresses
  logic [7:0] rq[$]; // expected read data
  int n_fail, n_tests, n_done, seed, i;
  initial begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end
  dma_ctrl i_dut (
    .clk(clk), .reset_n(reset_n), .chip_select_n(chip_select_n),
    .register_select_in(register_select_in), .data_bus_in(data_bus_in),
    .io_read_strobe_in_n(io_read_strobe_in_n),
    .io_write_strobe_in_n(io_write_strobe_in_n),
    .channel_request(channel_request), .bus_hold_grant(bus_hold_grant),
    .ready(ready), .terminate_in_n(terminate_in_n),
    .channel_grant(channel_grant), .bus_hold_request(bus_hold_request),
    .low_transfer_address_out(lo_a), .high_transfer_address_out(hi_a),
    .address_out_valid_n(), .upper_byte_bus_enable(),
    .upper_byte_latch_strobe(upper_byte_latch_strobe),
    .data_bus_out(data_bus_out), .data_out_valid_n(data_out_valid_n),
    .io_read_strobe_out_n(), .io_write_strobe_out_n(),
    .command_out_valid_n(), .mem_read_strobe_n(), .mem_write_strobe_n(),
    .finished_out_n(finished_out_n), .finished_out_valid_n()
  );
  host_bus_model i_host (
    .clk(clk), .reset_n(reset_n), .slow(slow),
    .bus_hold_request(bus_hold_request), .bus_hold_grant(bus_hold_grant),
    .ready(ready)
  );
  task cmp(input logic [15:0] got, input logic [15:0] exp);
    n_tests++;
    if (got !== exp) begin
      n_fail++;
      $display("mismatch at %0t: got %h exp %h", $time, got, exp);
    end
  endtask
  task results;
    $display("comparisons %0d, mismatches %0d", n_tests, n_fail);
    if (n_fail == 0 && n_tests > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask
  // one write: strobe low one cycle, then high one cycle
  task wr(input logic [3:0] ad, input logic [7:0] d);
    chip_select_n <= 1'b0;
    register_select_in <= ad;
    data_bus_in <= d;
    io_write_strobe_in_n <= 1'b0;
    @(posedge clk);
    chip_select_n <= 1'b1;
    io_write_strobe_in_n <= 1'b1;
    @(posedge clk);
  endtask
  // read held three cycles so the monitor sees settled data
  task rd(input logic [3:0] ad, input logic [7:0] e);
    rq.push_back(e);
    chip_select_n <= 1'b0;
    register_select_in <= ad;
    io_read_strobe_in_n <= 1'b0;
    repeat (3) @(posedge clk);
    chip_select_n <= 1'b1;
    io_read_strobe_in_n <= 1'b1;
    @(posedge clk);
  endtask
  // address and count go low byte first, pointer cleared beforehand
  task prog(input logic [1:0] ch, input logic [15:0] ad,
            input logic [15:0] n, input logic [7:0] md);
    wr(SEL_CLRFF, 8'h00);
    wr({1'b0, ch, 1'b0}, ad[7:0]);
    wr({1'b0, ch, 1'b0}, ad[15:8]);
    wr({1'b0, ch, 1'b1}, n[7:0]);
    wr({1'b0, ch, 1'b1}, n[15:8]);
    wr(SEL_MODE, {md[7:2], ch});
    wr(SEL_MASK1, {6'h00, ch});
  endtask
  // raise requests, wait for the finishes and a released bus
  task run(input logic [3:0] req, input int nfin);
    int base;
    int k;
    base = n_done;
    channel_request <= req;
    for (k = 0; k < 400 && (n_done < base + nfin || bus_hold_grant ||
         bus_hold_request); k++) begin
      @(posedge clk);
    end
    if (k == 400) begin
      n_fail++;
      results();
    end
    // served peripherals let go of their requests
    channel_request <= 4'h0;
  endtask
  // monitor: compare each address cycle and each read answer
  always @(posedge clk) begin
    if (upper_byte_latch_strobe === 1'b1) begin
      cmp({data_bus_out, hi_a, lo_a},
          aq.size() > 0 ? aq.pop_front() : 16'hxxxx);
    end
    if (finished_out_n === 1'b0) begin
      n_done <= n_done + 1;
    end
    if (!chip_select_n && !io_read_strobe_in_n && !rd_seen &&
        data_out_valid_n === 1'b0) begin
      cmp({8'h00, data_bus_out}, {8'h00, rq.pop_front()});
      rd_seen = 1'b1;
    end
    if (io_read_strobe_in_n) begin
      rd_seen = 1'b0;
    end
  end
  initial begin
    seed = 63141;
    {reset_n, slow, rd_seen, n_fail, n_tests, n_done} = '0;
    {chip_select_n, io_read_strobe_in_n, io_write_strobe_in_n} = 3'h7;
    terminate_in_n = 1'b1;
    register_select_in = 4'h0;
    data_bus_in = 8'h00;
    channel_request = 4'h0;
    repeat (6) @(posedge clk);
    reset_n <= 1'b1;
    @(posedge clk);
    cmp({11'h000, channel_grant, bus_hold_request}, 16'h001e);
    rd(SEL_MASKALL, {4'h0, MASK_RST});
    $display("test reset done");
    a = 16'($random(seed));
    aq.push_back(a);
    aq.push_back(a + 16'h0001);
    prog(2'h0, a, 16'h0001, {4'h0, XT_TOMEM, 2'h0});
    run(4'h1, 1);
    rd(SEL_CMD, 8'h01);
    $display("test single up done");
    slow <= 1'b1;
    a = 16'($random(seed));
    for (i = 0; i < 3; i++) begin
      aq.push_back(a - 16'(i));
    end
    prog(2'h2, a, 16'h0002, {SM_BLOCK, 2'h2, XT_TOMEM, 2'h0});
    run(4'h4, 1);
    rd(SEL_CMD, 8'h04);
    $display("test block down slow done");
    slow <= 1'b0;
    a = 16'($random(seed));
    aq.push_back(a);
    aq.push_back(a + 16'h0100);
    prog(2'h0, a, 16'h0000, {4'h0, XT_TOMEM, 2'h0});
    prog(2'h1, a + 16'h0100, 16'h0000, {4'h0, XT_TOMEM, 2'h0});
    run(4'h3, 2);
    rd(SEL_CMD, 8'h03);
    $display("test fixed priority done");
    // external terminate cuts a long block after its first byte
    terminate_in_n <= 1'b0;
    a = 16'($random(seed));
    aq.push_back(a);
    prog(2'h3, a, 16'h0005, {SM_BLOCK, 2'h0, XT_TOMEM, 2'h0});
    run(4'h8, 1);
    terminate_in_n <= 1'b1;
    rd(SEL_CMD, 8'h08);
    cmp(16'(aq.size()), 16'h0000);
    $display("test terminate done");
    results();
  end
endmodule // tb_top
